// File: hw/apparent_energy_accumulator.sv
`timescale 1ns/1ps
module apparent_energy_accumulator #(
  parameter int RMS_W = energy_pkg::RMS_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [RMS_W-1:0] vrms_in,
  input wire logic [RMS_W-1:0] irms_in,
  input wire logic zero_cross_in,
  input wire logic [energy_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [energy_pkg::DATA_W-1:0] reg_wdata,
  output logic [energy_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic irq_n,
  output logic window_end
);
  localparam int ACC_W = energy_pkg::ACC_W;
  localparam int EW = energy_pkg::ENERGY_W;
  localparam int LSB = energy_pkg::ENERGY_LSB;
  localparam int DW = energy_pkg::DIV_W;
  localparam int HW = energy_pkg::HCC_W;
  localparam int GW = energy_pkg::GAIN_W;
  localparam int SWD = energy_pkg::STAT_W;
  localparam int DTW = energy_pkg::DATA_W;

  if (RMS_W < 12 || RMS_W > 32) begin : g_chk
    $error("apparent_energy_accumulator supports rms widths 12 to 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [DW-1:0] div_cnt;
    logic [EW-1:0] total;
    logic [EW-1:0] cor;
    logic [EW-1:0] line_acc;
    logic [EW-1:0] line_res;
    logic [HW-1:0] hcc_cnt;
    logic armed;
    logic [GW-1:0] gain;
    logic [DW-1:0] div;
    logic [HW-1:0] hcc;
    logic [SWD-1:0] status;
    logic [SWD-1:0] enable;
    logic [DTW-1:0] rdata;
    logic rvalid;
    logic irq_n;
    logic win_end;
  } st_t;

  localparam st_t ST_RST = '{
    acc: '0, div_cnt: '0, total: '0, cor: '0, line_acc: '0, line_res: '0,
    hcc_cnt: '0, armed: 1'b0, gain: energy_pkg::GAIN_RST,
    div: energy_pkg::DIV_RST, hcc: energy_pkg::HCC_RST, status: '0,
    enable: energy_pkg::ENABLE_RST, rdata: '0, rvalid: 1'b0,
    irq_n: 1'b1, win_end: 1'b0
  };

  st_t state_reg;
  st_t state_next;

  // ----------------------------------------------------------------
  // sample source
  // ----------------------------------------------------------------
  logic step;
  power_if pw ();

  step_timer #(
    .STEPS(energy_pkg::STEP_CYCLES)
  ) u_step (
    .ref_clk(ref_clk),
    .srst(srst),
    .strobe(step)
  );

  power_scaler #(
    .RMS_W(RMS_W)
  ) u_scale (
    .ref_clk(ref_clk),
    .srst(srst),
    .strobe(step),
    .vrms(vrms_in),
    .irms(irms_in),
    .gain(state_reg.gain),
    .pw(pw)
  );

  // ----------------------------------------------------------------
  // accumulate and divide
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] sample_ext;
  logic [ACC_W-1:0] acc_sum;
  logic [DW-1:0] div_eff;
  logic tick;
  logic etick;
  logic win_close;
  logic cor_read;
  logic stat_wr;

  // a zero bit is prepended before sign extension, so every sample counts up
  assign sample_ext = ACC_W'($signed({1'b0, pw.sample}));
  assign acc_sum = ACC_W'(state_reg.acc + sample_ext);
  // carry into the top 24 bits is one energy step before division
  assign tick = pw.valid && (acc_sum[ACC_W-1:LSB] != state_reg.acc[ACC_W-1:LSB]);
  assign div_eff = (state_reg.div == '0) ? DW'(1) : state_reg.div;
  // division done by counting carries, avoids a wide divider
  assign etick = tick && (DW'(state_reg.div_cnt + 1'b1) >= div_eff);
  // window closes on the crossing that completes the count
  assign win_close = zero_cross_in && state_reg.armed && (state_reg.hcc != '0)
                     && (HW'(state_reg.hcc_cnt + 1'b1) >= state_reg.hcc);
  assign cor_read = reg_rd && (reg_addr == energy_pkg::ADDR_COR);
  assign stat_wr = reg_wr && (reg_addr == energy_pkg::ADDR_STATUS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.win_end = 1'b0;
    state_next.rvalid = reg_rd;

    // accumulator takes every sample, nothing gates it
    if (pw.valid) begin
      state_next.acc = acc_sum;
    end
    if (tick) begin
      state_next.div_cnt = etick ? '0 : DW'(state_reg.div_cnt + 1'b1);
    end

    // total wraps modulo its width
    if (etick) begin
      state_next.total = EW'(state_reg.total + 1'b1);
    end

    // a read clears the copy, but a step in the same cycle survives
    if (cor_read) begin
      state_next.cor = etick ? EW'(1) : '0;
    end else if (etick) begin
      state_next.cor = EW'(state_reg.cor + 1'b1);
    end

    // line window: same energy steps as the total, no enable bit
    if (state_reg.armed && etick) begin
      state_next.line_acc = EW'(state_reg.line_acc + 1'b1);
    end
    if (zero_cross_in) begin
      if (!state_reg.armed) begin
        state_next.armed = 1'b1;
        state_next.hcc_cnt = '0;
        state_next.line_acc = '0;
      end else if (win_close) begin
        state_next.line_res = EW'(state_reg.line_acc + {{(EW-1){1'b0}}, etick});
        state_next.line_acc = '0;
        state_next.hcc_cnt = '0;
        state_next.win_end = 1'b1;
      end else begin
        state_next.hcc_cnt = HW'(state_reg.hcc_cnt + 1'b1);
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        energy_pkg::ADDR_GAIN: state_next.gain = reg_wdata[GW-1:0];
        energy_pkg::ADDR_DIV: state_next.div = reg_wdata[DW-1:0];
        energy_pkg::ADDR_HCC: state_next.hcc = reg_wdata[HW-1:0];
        energy_pkg::ADDR_ENABLE: state_next.enable = reg_wdata[SWD-1:0];
        default: state_next.gain = state_reg.gain;
      endcase
    end

    // status: write one clears, a set in the same cycle wins
    if (stat_wr) begin
      state_next.status = state_reg.status & ~reg_wdata[SWD-1:0];
    end
    if (etick && state_reg.total == energy_pkg::FULL_LAST) begin
      state_next.status[energy_pkg::STAT_OVF_BIT] = 1'b1;
    end
    if (etick && state_reg.total == energy_pkg::HALF_LAST) begin
      state_next.status[energy_pkg::STAT_HALF_BIT] = 1'b1;
    end
    if (win_close) begin
      state_next.status[energy_pkg::STAT_WIN_BIT] = 1'b1;
    end
    state_next.irq_n = ~|(state_next.status & state_next.enable);

    // read data, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        energy_pkg::ADDR_GAIN: state_next.rdata = DTW'(state_reg.gain);
        energy_pkg::ADDR_TOTAL: state_next.rdata = DTW'(state_reg.total);
        energy_pkg::ADDR_DIV: state_next.rdata = DTW'(state_reg.div);
        energy_pkg::ADDR_COR: state_next.rdata = DTW'(state_reg.cor);
        energy_pkg::ADDR_LINE: state_next.rdata = DTW'(state_reg.line_res);
        energy_pkg::ADDR_HCC: state_next.rdata = DTW'(state_reg.hcc);
        energy_pkg::ADDR_STATUS: state_next.rdata = DTW'(state_reg.status);
        energy_pkg::ADDR_ENABLE: state_next.rdata = DTW'(state_reg.enable);
        default: state_next.rdata = '0;
      endcase
    end
  end

  // one register for all state; reset loads the table above
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign irq_n = state_reg.irq_n;
  assign window_end = state_reg.win_end;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_STEP_SPACING: assert property (
    pw.valid |=> !pw.valid [*3] ##1 pw.valid)
    else $error("samples not four clocks apart");

  AST_ACC_SIGNED_ADD: assert property (
    pw.valid |=> state_reg.acc == ACC_W'($past(state_reg.acc) + $past(sample_ext)))
    else $error("accumulator did not add the sample");

  AST_ACC_HOLD: assert property (
    !pw.valid |=> $stable(state_reg.acc))
    else $error("accumulator moved without a sample");

  AST_DIV_ZERO_ONE: assert property (
    tick && state_reg.div == '0 |=> state_reg.total == EW'($past(state_reg.total) + 1'b1))
    else $error("zero divider does not act as one");

  AST_DIV_COUNT: assert property (
    $changed(state_reg.total) |-> $past(etick))
    else $error("total moved without a divided step");

  AST_COR_CLEAR: assert property (
    cor_read && !etick |=> state_reg.cor == '0 ##0 reg_rvalid)
    else $error("clear-on-read copy not zeroed");

  AST_OVF_WRAP: assert property (
    etick && state_reg.total == energy_pkg::FULL_LAST
    |=> state_reg.total == '0 && state_reg.status[energy_pkg::STAT_OVF_BIT])
    else $error("overflow did not wrap and flag");

  AST_HALF_FULL: assert property (
    etick && state_reg.total == energy_pkg::HALF_LAST
    |=> state_reg.status[energy_pkg::STAT_HALF_BIT])
    else $error("half full flag missing");

  AST_WIN_DONE: assert property (
    win_close |=> window_end && state_reg.status[energy_pkg::STAT_WIN_BIT]
    && state_reg.line_acc == '0)
    else $error("window end not flagged or not restarted");

  AST_WIN_IRQ: assert property (
    win_close && state_reg.enable[energy_pkg::STAT_WIN_BIT] |=> !irq_n)
    else $error("enabled window end did not pull irq low");

  AST_WIN_PULSE: assert property (
    window_end |-> $past(zero_cross_in) ##1 !window_end)
    else $error("window end not a single pulse on a crossing");

  // register port answers come from the state seen at the strobe
  AST_READ_TOTAL: assert property (
    reg_rd && reg_addr == energy_pkg::ADDR_TOTAL
    |=> reg_rvalid && reg_rdata == DTW'($past(state_reg.total)))
    else $error("total read returned a wrong value");

  AST_READ_COR: assert property (
    cor_read |=> reg_rvalid && reg_rdata == DTW'($past(state_reg.cor)))
    else $error("clear-on-read copy returned a wrong value");

  AST_RVALID_IDLE: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without a read strobe");

  AST_GAIN_WRITE: assert property (
    reg_wr && reg_addr == energy_pkg::ADDR_GAIN
    |=> state_reg.gain == $past(reg_wdata[GW-1:0]))
    else $error("gain word write did not land");

  // clear-on-read copy counts the same steps as the total
  AST_COR_STEP: assert property (
    cor_read && etick |=> state_reg.cor == EW'(1))
    else $error("step lost when it met a clearing read");

  AST_COR_COUNT: assert property (
    !cor_read && etick |=> state_reg.cor == EW'($past(state_reg.cor) + 1'b1))
    else $error("clear-on-read copy missed a step");

  AST_COR_HOLD: assert property (
    !cor_read && !etick |=> $stable(state_reg.cor))
    else $error("clear-on-read copy moved on its own");

  // total moves by exactly one per divided step
  AST_TOTAL_STEP: assert property (
    etick |=> state_reg.total == EW'($past(state_reg.total) + 1'b1))
    else $error("total did not step by one");

  // with a divider above one the first carry of a round is held back
  AST_DIV_FIRST_HELD: assert property (
    tick && state_reg.div_cnt == '0 && state_reg.div > DW'(1)
    |=> $stable(state_reg.total))
    else $error("divider let the first carry through");

  // window count and end pulse move only on crossings; line energy moves on steps
  AST_ARM_FIRST: assert property (
    !state_reg.armed && zero_cross_in
    |=> state_reg.armed && state_reg.line_acc == '0 && !window_end)
    else $error("first crossing did not just arm the window");

  AST_CROSS_ONLY: assert property (
    !zero_cross_in |=> $stable(state_reg.hcc_cnt) && !window_end)
    else $error("window count moved without a crossing");

  AST_LINE_COUNT: assert property (
    state_reg.armed && etick && !zero_cross_in
    |=> state_reg.line_acc == EW'($past(state_reg.line_acc) + 1'b1))
    else $error("line energy missed a step");

  // status bits are sticky until written with a one
  AST_STATUS_STICKY: assert property (
    !stat_wr |=> (state_reg.status & $past(state_reg.status)) == $past(state_reg.status))
    else $error("status bit dropped without a clear");

  AST_STATUS_CLEAR: assert property (
    stat_wr && reg_wdata[energy_pkg::STAT_WIN_BIT] && !win_close
    |=> !state_reg.status[energy_pkg::STAT_WIN_BIT])
    else $error("window done flag did not clear");

  COV_WINDOW: cover property (win_close ##1 window_end);
  COV_OVERFLOW: cover property (etick && state_reg.total == energy_pkg::FULL_LAST);
  COV_COR_READ: cover property (cor_read && state_reg.cor != '0);
  COV_IRQ: cover property ($fell(irq_n));
  COV_DIV_HELD: cover property (tick && !etick);
endmodule : apparent_energy_accumulator

// File: hw/energy_pkg.sv
package energy_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RMS_W = 24;
  localparam int POWER_W = 24;
  localparam int GAIN_W = 12;
  localparam int SAMPLE_W = 25;
  localparam int ACC_W = 49;
  localparam int ENERGY_W = 24;
  localparam int DIV_W = 8;
  localparam int HCC_W = 16;
  localparam int STAT_W = 3;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;

  // ----------------------------------------------------------------
  // timing and field positions
  // ----------------------------------------------------------------
  localparam int STEP_CYCLES = 4;
  localparam int ENERGY_LSB = ACC_W - ENERGY_W;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_HALF_BIT = 1;
  localparam int STAT_WIN_BIT = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_GAIN = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_TOTAL = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_DIV = 6'h12;
  localparam logic [ADDR_W-1:0] ADDR_COR = 6'h13;
  localparam logic [ADDR_W-1:0] ADDR_LINE = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_HCC = 6'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 6'h21;

  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [HCC_W-1:0] HCC_RST = 16'hFFFF;
  localparam logic [STAT_W-1:0] ENABLE_RST = 3'h0;
  localparam logic [GAIN_W:0] GAIN_UNITY = 13'h1000;
  localparam logic [ENERGY_W-1:0] HALF_LAST = 24'h7FFFFF;
  localparam logic [ENERGY_W-1:0] FULL_LAST = 24'hFFFFFF;

endpackage : energy_pkg

// File: hw/power_if.sv
`timescale 1ns/1ps
// scaled apparent power sample, valid for one cycle per step
interface power_if;
  logic [energy_pkg::SAMPLE_W-1:0] sample;
  logic valid;
  modport src (output sample, output valid);
  modport dst (input sample, input valid);
endinterface : power_if

// File: hw/power_scaler.sv
`timescale 1ns/1ps
module power_scaler #(
  parameter int RMS_W = energy_pkg::RMS_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic strobe,
  input wire logic [RMS_W-1:0] vrms,
  input wire logic [RMS_W-1:0] irms,
  input wire logic [energy_pkg::GAIN_W-1:0] gain,
  power_if.src pw
);
  localparam int PW = energy_pkg::POWER_W;
  localparam int GW = energy_pkg::GAIN_W;
  localparam int SW = energy_pkg::SAMPLE_W;

  if (2 * RMS_W < PW) begin : g_chk
    $error("power_scaler rms width too small for power word");
  end

  typedef struct packed {
    logic [SW-1:0] sample;
    logic valid;
  } st_t;

  st_t state_reg;
  st_t state_next;
  logic [2*RMS_W-1:0] prod;
  logic [PW-1:0] ap;
  logic [GW:0] factor;
  logic [PW+GW:0] scaled;

  // product of the two rms values; phase plays no part, no offset term
  assign prod = vrms * irms;
  assign ap = prod[2*RMS_W-1 -: PW];
  // gain word is signed, so unity plus sign-extended word stays positive
  assign factor = energy_pkg::GAIN_UNITY + {gain[GW-1], gain};
  assign scaled = ap * factor;

  // register one scaled sample per step
  always_comb begin
    state_next = state_reg;
    state_next.valid = strobe;
    if (strobe) begin
      state_next.sample = scaled[PW+GW -: SW];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pw.sample = state_reg.sample;
  assign pw.valid = state_reg.valid;

  AST_UNITY_GAIN: assert property (@(posedge ref_clk) disable iff (srst)
    strobe && gain == '0 |=> pw.sample == {1'b0, $past(ap)})
    else $error("unity gain sample is not the rms product");
endmodule : power_scaler

// File: hw/step_timer.sv
`timescale 1ns/1ps
module step_timer #(
  parameter int STEPS = energy_pkg::STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  output logic strobe
);
  localparam int CNT_W = $clog2(STEPS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEPS - 1);

  if (STEPS < 2) begin : g_chk
    $error("step_timer needs at least two cycles per step");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic strobe;
  } st_t;

  st_t state_reg;
  st_t state_next;

  // free running divider, one strobe per step
  always_comb begin
    state_next = state_reg;
    state_next.strobe = (state_reg.cnt == CNT_LAST);
    state_next.cnt = (state_reg.cnt == CNT_LAST) ? '0 : CNT_W'(state_reg.cnt + 1'b1);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign strobe = state_reg.strobe;
endmodule : step_timer

// File: verification/host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module host_model (
  input wire logic ref_clk,
  output logic [energy_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [energy_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [energy_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus: strobes low, address and data parked on a pattern
  initial begin
    reg_addr = 6'h3F;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 24'h5A5A5A;
  end

  // one-cycle write strobe; released lines show the inverse, not the old value
  task automatic wr(input logic [energy_pkg::ADDR_W-1:0] a,
                    input logic [energy_pkg::DATA_W-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // answer lands one cycle after the strobe; x if no valid pulse came
  task automatic rd(input logic [energy_pkg::ADDR_W-1:0] a,
                    output logic [energy_pkg::DATA_W-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask : rd
endmodule : host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk;
  logic srst;
  logic [energy_pkg::RMS_W-1:0] vrms;
  logic [energy_pkg::RMS_W-1:0] irms;
  logic zx;
  logic [energy_pkg::ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [energy_pkg::DATA_W-1:0] reg_wdata;
  logic [energy_pkg::DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic irq_n;
  logic window_end;
  int n_mismatch;
  int checked;
  int cyc = 0;
  int last_zx;

  apparent_energy_accumulator uut (.ref_clk(ref_clk), .srst(srst), .vrms_in(vrms),
    .irms_in(irms), .zero_cross_in(zx), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq_n(irq_n), .window_end(window_end));

  host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ----------------------------------------------------------------
  // clock and cycle count
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // tolerance absorbs the unknown phase of the four-cycle step
  task automatic chk(input logic [23:0] got, input logic [23:0] e, input int tol);
    checked++;
    if (!(got === e || (^got !== 1'bx && got + tol >= e && got <= e + tol))) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic rchk(input logic [5:0] a, input logic [23:0] e, input int tol);
    logic [23:0] d;
    host.rd(a, d);
    chk(d, e, tol);
  endtask : rchk

  // crossing pulses stay well apart; cycle of each is kept for expectations
  task automatic pulse();
    repeat (1000) @(negedge ref_clk);
    zx = 1'b1;
    last_zx = cyc;
    @(negedge ref_clk);
    zx = 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(energy_pkg::ADDR_GAIN, 24'h000000, 0);
    rchk(energy_pkg::ADDR_DIV, 24'h000000, 0);
    rchk(energy_pkg::ADDR_HCC, 24'h00FFFF, 0);
    rchk(energy_pkg::ADDR_STATUS, 24'h000000, 0);
    rchk(energy_pkg::ADDR_TOTAL, 24'h000000, 0);
    rchk(energy_pkg::ADDR_COR, 24'h000000, 0);
    rchk(energy_pkg::ADDR_ENABLE, 24'h000000, 0);
    rchk(energy_pkg::ADDR_LINE, 24'h000000, 0);
    rchk(6'h3F, 24'h000000, 0); // unmapped place reads zero
    chk({23'h0, irq_n}, 24'h000001, 0);
  endtask : t_reset

  task automatic t_regs();
    host.wr(energy_pkg::ADDR_GAIN, 24'hFFFFFF);
    rchk(energy_pkg::ADDR_GAIN, 24'h000FFF, 0);
    host.wr(energy_pkg::ADDR_DIV, 24'hFFFFFF);
    rchk(energy_pkg::ADDR_DIV, 24'h0000FF, 0);
    host.wr(energy_pkg::ADDR_HCC, 24'hFFFFFF);
    rchk(energy_pkg::ADDR_HCC, 24'h00FFFF, 0);
    host.wr(energy_pkg::ADDR_ENABLE, 24'hFFFFFF);
    rchk(energy_pkg::ADDR_ENABLE, 24'h000007, 0);
    chk({23'h0, irq_n}, 24'h000001, 0);
    host.wr(energy_pkg::ADDR_TOTAL, 24'h123456);
    rchk(energy_pkg::ADDR_TOTAL, 24'h000000, 0);
  endtask : t_regs

  // energy over about 4096 clocks for each power, gain and divider setting
  task automatic t_energy();
    logic [23:0] v [7];
    logic [23:0] i [7];
    logic [11:0] g [7];
    logic [7:0] dv [7];
    logic [23:0] c;
    logic [23:0] t0;
    logic [23:0] t1;
    longint p;
    longint e;
    v = '{24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h0};
    i = '{24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h400000, 24'h800000};
    g = '{12'h000, 12'h000, 12'h000, 12'h7FF, 12'h800, 12'h000, 12'h000};
    dv = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 7; k++) begin
      host.wr(energy_pkg::ADDR_GAIN, {12'h0, g[k]});
      host.wr(energy_pkg::ADDR_DIV, {16'h0, dv[k]});
      @(negedge ref_clk);
      vrms = v[k];
      irms = i[k];
      repeat (64) @(negedge ref_clk);
      host.rd(energy_pkg::ADDR_COR, c);
      host.rd(energy_pkg::ADDR_TOTAL, t0);
      repeat (4094) @(negedge ref_clk);
      host.rd(energy_pkg::ADDR_COR, c);
      host.rd(energy_pkg::ADDR_TOTAL, t1);
      p = ((longint'(v[k]) * longint'(i[k])) >> 24) * (4096 + int'($signed(g[k]))) / 4096;
      e = ((p * 1024 + 64'h1000000) >> 25) / ((dv[k] == 8'h00) ? 1 : dv[k]);
      chk(c, 24'(e), 1);
      chk(t1 - t0, c, 1);
      rchk(energy_pkg::ADDR_COR, 24'h000000, 1);
    end
  endtask : t_energy

  task automatic close_window(input logic expect_end, input logic irq_on);
    int c0;
    logic [23:0] d;
    c0 = last_zx;
    pulse();
    pulse();
    for (int k = 0; k < 4 && window_end !== 1'b1; k++) @(negedge ref_clk);
    chk({23'h0, window_end}, {23'h0, expect_end}, 0);
    if (expect_end && window_end !== 1'b1) end_of_test();
    if (expect_end) begin
      @(negedge ref_clk);
      chk({23'h0, window_end}, 24'h000000, 0);
      host.rd(energy_pkg::ADDR_LINE, d);
      chk(d, 24'((last_zx - c0) / 32), 1);
      rchk(energy_pkg::ADDR_STATUS, 24'h000004, 0);
      chk({23'h0, irq_n}, {23'h0, ~irq_on}, 0);
      host.wr(energy_pkg::ADDR_STATUS, 24'h000004);
      rchk(energy_pkg::ADDR_STATUS, 24'h000000, 0);
      chk({23'h0, irq_n}, 24'h000001, 0);
    end
  endtask : close_window

  task automatic t_window();
    host.wr(energy_pkg::ADDR_GAIN, 24'h000000);
    host.wr(energy_pkg::ADDR_DIV, 24'h000000);
    host.wr(energy_pkg::ADDR_HCC, 24'h000002);
    host.wr(energy_pkg::ADDR_ENABLE, 24'h000004);
    @(negedge ref_clk);
    vrms = 24'h800000;
    irms = 24'h800000;
    pulse();
    close_window(1'b1, 1'b1);
    close_window(1'b1, 1'b1);
    host.wr(energy_pkg::ADDR_ENABLE, 24'h000000);
    close_window(1'b1, 1'b0);
    host.wr(energy_pkg::ADDR_HCC, 24'h000000);
    close_window(1'b0, 1'b0);
  endtask : t_window

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    vrms = '0;
    irms = '0;
    zx = 1'b0;
    n_mismatch = 0;
    checked = 0;
    last_zx = 0;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_regs();
    t_energy();
    t_window();
    end_of_test();
  end
endmodule : tb_top
